/* File: hw/sdrci_top.sv */
// device-side command sequencer of a four-bank sdram
// What this block does
// - data outputs high impedance during initialisation
// - auto refresh uses internal row counter
// - whole clock spacings hold at any period
// - full-page burst leaves row open
// - column address ignores A8 and A9
`include "sdrci_defs.svh"
`default_nettype none
module sdrci_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cke,
  input wire sdrci_pkg::sdrci_cmd_s cmd,
  input wire logic [1:0] ba,
  input wire logic [10:0] addr,
  output logic dq_oe,
  output logic ready,
  output logic [3:0] bank_open,
  output logic [11:0] refresh_row,
  output logic [7:0] col_addr,
  output logic timing_err
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] burst_beats(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h1;
    if (code == `SDRCI_BL_FULL_PAGE) begin
      n = `SDRCI_FULL_PAGE_BEATS;
    end else if (code[2] == 1'b0) begin
      n = 9'(9'h1 << code[1:0]);
    end
    return n;
  endfunction

  // ****************************************
  // command decode
  // ****************************************
  sdrci_pkg::sdrci_op_e op;
  logic act;

  always_comb begin
    act = cke && !cmd.cs_n;
    op = act ? sdrci_pkg::sdrci_op_e'({cmd.ras_n, cmd.cas_n, cmd.we_n}) : sdrci_pkg::SDRCI_NOP;
  end

  // ****************************************
  // state
  // ****************************************
  sdrci_pkg::sdrci_state_s s_q;
  sdrci_pkg::sdrci_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (cke) begin
      if (s_q.gap_cnt != 2'h0) begin
        s_d.gap_cnt = s_q.gap_cnt - 2'h1;
      end
      // read data window and burst end
      if (s_q.lat_cnt > 3'h1) begin
        s_d.lat_cnt = s_q.lat_cnt - 3'h1;
      end else if (s_q.lat_cnt == 3'h1) begin
        s_d.lat_cnt = 3'h0;
        s_d.dq_oe = s_q.is_read && s_q.phase == sdrci_pkg::SDRCI_READY;
      end else if (s_q.beats != 9'h0 && !s_q.full_run) begin
        s_d.beats = s_q.beats - 9'h1;
        if (s_q.beats == 9'h1) begin
          s_d.dq_oe = 1'b0;
          if (s_q.ap_pend) begin
            s_d.bank_open[s_q.ap_bank] = 1'b0;
            s_d.ap_pend = 1'b0;
          end
        end
      end
      if (act && s_q.phase == sdrci_pkg::SDRCI_PWRUP) begin
        s_d.phase = sdrci_pkg::SDRCI_INIT;
      end
      case (op)
        sdrci_pkg::SDRCI_MODE_LOAD: begin
          s_d.burst_length = addr[`SDRCI_MODE_BL_LSB +: 3];
          s_d.read_latency = addr[`SDRCI_MODE_RL_LSB +: 3];
          s_d.mode_done = 1'b1;
          s_d.gap_cnt = `SDRCI_MODE_LOAD_TO_COMMAND_GAP - 2'h1;
        end
        sdrci_pkg::SDRCI_REFRESH: begin
          s_d.ref_row = s_q.ref_row + 12'h1;
          if (s_q.wake_cnt != `SDRCI_WAKE_REFRESHES) begin
            s_d.wake_cnt = s_q.wake_cnt + 2'h1;
          end
          if (s_q.gap_cnt != 2'h0) begin
            s_d.timing_err = 1'b1;
          end
        end
        sdrci_pkg::SDRCI_ACTIVATE: begin
          s_d.bank_open[ba] = 1'b1;
          if (s_q.gap_cnt != 2'h0) begin
            s_d.timing_err = 1'b1;
          end
        end
        sdrci_pkg::SDRCI_PRECHARGE: begin
          if (addr[`SDRCI_AUTO_PRE_BIT]) begin
            s_d.bank_open = 4'h0;
          end else begin
            s_d.bank_open[ba] = 1'b0;
          end
          s_d.full_run = 1'b0;
          s_d.beats = 9'h0;
          s_d.lat_cnt = 3'h0;
          s_d.dq_oe = 1'b0;
          s_d.ap_pend = 1'b0;
        end
        sdrci_pkg::SDRCI_READ, sdrci_pkg::SDRCI_WRITE: begin
          s_d.col = addr[`SDRCI_COL_W-1:0];
          s_d.is_read = op == sdrci_pkg::SDRCI_READ;
          s_d.beats = burst_beats(s_q.burst_length);
          s_d.full_run = s_q.burst_length == `SDRCI_BL_FULL_PAGE;
          s_d.ap_pend = addr[`SDRCI_AUTO_PRE_BIT] && !s_d.full_run;
          s_d.ap_bank = ba;
          if (op == sdrci_pkg::SDRCI_READ) begin
            s_d.lat_cnt = s_q.read_latency;
            s_d.dq_oe = 1'b0;
          end else begin
            s_d.lat_cnt = 3'h0;
            s_d.dq_oe = 1'b0;
          end
        end
        sdrci_pkg::SDRCI_BURST_STOP: begin
          s_d.full_run = 1'b0;
          s_d.beats = 9'h0;
          s_d.lat_cnt = 3'h0;
          s_d.dq_oe = 1'b0;
        end
        default: begin
        end
      endcase
      if (s_q.phase == sdrci_pkg::SDRCI_INIT && s_d.mode_done
          && s_d.wake_cnt == `SDRCI_WAKE_REFRESHES) begin
        s_d.phase = sdrci_pkg::SDRCI_READY;
      end
      if (s_d.phase != sdrci_pkg::SDRCI_READY) begin
        s_d.dq_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{phase: sdrci_pkg::SDRCI_PWRUP, burst_length: `SDRCI_BL_RESET,
               read_latency: `SDRCI_RL_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign dq_oe = s_q.dq_oe;
  // phase bit 1 is set only in the ready phase
  assign ready = s_q.phase[1];
  assign bank_open = s_q.bank_open;
  assign refresh_row = s_q.ref_row;
  assign col_addr = s_q.col;
  assign timing_err = s_q.timing_err;

  // ****************************************
  // checks
  // ****************************************
  init_high_z_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_q.phase != sdrci_pkg::SDRCI_READY |-> !dq_oe)
    else $error("data outputs driven before initialisation ends");

  refresh_count_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    op == sdrci_pkg::SDRCI_REFRESH |=> refresh_row == $past(refresh_row) + 12'h1)
    else $error("refresh row counter did not advance");

  mode_gap_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    op == sdrci_pkg::SDRCI_MODE_LOAD
    ##1 (op == sdrci_pkg::SDRCI_REFRESH || op == sdrci_pkg::SDRCI_ACTIVATE) |=> timing_err)
    else $error("command too soon after mode load not flagged");

  full_page_open_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (op == sdrci_pkg::SDRCI_READ && s_q.burst_length == `SDRCI_BL_FULL_PAGE
     && bank_open[ba]) ##1 (op == sdrci_pkg::SDRCI_NOP)[*3] |=> bank_open[$past(ba, 4)])
    else $error("full-page burst closed its row");

  column_mask_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (op == sdrci_pkg::SDRCI_READ || op == sdrci_pkg::SDRCI_WRITE)
    |=> col_addr == $past(addr[7:0]))
    else $error("column address not taken from A0 to A7");

endmodule
`default_nettype wire

/* File: hw/sdrci_defs.svh */
// constants for the sdram command sequencing block
`ifndef SDRCI_DEFS_SVH
`define SDRCI_DEFS_SVH

// ****************************************
// geometry
// ****************************************
`define SDRCI_ROW_W 11
`define SDRCI_COL_W 8
`define SDRCI_BANKS 4
`define SDRCI_REF_ROW_W 12
`define SDRCI_BEAT_W 9
`define SDRCI_FULL_PAGE_BEATS 9'h100

// ****************************************
// mode register fields on the address pins
// ****************************************
`define SDRCI_MODE_BL_LSB 0
`define SDRCI_MODE_RL_LSB 4
`define SDRCI_BL_FULL_PAGE 3'h7
`define SDRCI_BL_RESET 3'h0
`define SDRCI_RL_RESET 3'h3
`define SDRCI_AUTO_PRE_BIT 10

// ****************************************
// timing in whole clocks, wake-up in refresh commands
// ****************************************
`define SDRCI_MODE_LOAD_TO_COMMAND_GAP 2'h2
`define SDRCI_WAKE_REFRESHES 2'h2

`endif

/* File: hw/sdrci_pkg.sv */
// types shared by the sdram command sequencing block
`default_nettype none
package sdrci_pkg;

  // ****************************************
  // command pins, sampled on the rising edge
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdrci_cmd_s;

  // ras_n, cas_n, we_n with chip select low
  typedef enum logic [2:0] {
    SDRCI_MODE_LOAD = 3'h0,
    SDRCI_REFRESH = 3'h1,
    SDRCI_PRECHARGE = 3'h2,
    SDRCI_ACTIVATE = 3'h3,
    SDRCI_WRITE = 3'h4,
    SDRCI_READ = 3'h5,
    SDRCI_BURST_STOP = 3'h6,
    SDRCI_NOP = 3'h7
  } sdrci_op_e;

  // power-up, initialising, ready (gray order)
  typedef enum logic [1:0] {
    SDRCI_PWRUP = 2'h0,
    SDRCI_INIT = 2'h1,
    SDRCI_READY = 2'h3
  } sdrci_phase_e;

  typedef struct packed {
    sdrci_phase_e phase;
    logic [1:0] wake_cnt;
    logic mode_done;
    logic [2:0] burst_length;
    logic [2:0] read_latency;
    logic [3:0] bank_open;
    logic [11:0] ref_row;
    logic [7:0] col;
    logic [1:0] gap_cnt;
    logic [2:0] lat_cnt;
    logic [8:0] beats;
    logic full_run;
    logic is_read;
    logic dq_oe;
    logic ap_pend;
    logic [1:0] ap_bank;
    logic timing_err;
  } sdrci_state_s;

endpackage
`default_nettype wire

/* File: tb/sdrci_ctl_model.sv */
// controller-side command driver for the sdram sequencer
`include "sdrci_defs.svh"
`default_nettype none
module sdrci_ctl_model #(
  parameter int WR_CLKS = 2, // two clocks of write recovery, one would do here
  parameter int PRE_CLKS = 1
) (
  input wire logic sys_clk,
  output logic cke,
  output var sdrci_pkg::sdrci_cmd_s cmd,
  output logic [1:0] ba,
  output logic [10:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  int clk_n = 0;
  int wr_done[4] = '{default: 0};
  logic [2:0] bl_code = `SDRCI_BL_RESET;
  logic [1:0] wr_bank = 2'h0;
  initial begin
    cke = 1'b1;
    cmd = 4'hF;
    ba = 2'h0;
    addr = 11'h000;
  end
  // free-running edge count for write recovery bookkeeping
  always @(posedge sys_clk) begin
    clk_n <= clk_n + 1;
  end
  function automatic int beats(input logic [2:0] code);
    return (code[2] == 1'b0) ? (1 << code[1:0]) : 1;
  endfunction
  // one command per edge; deselect after, with inverted bank and address lines
  task automatic issue(input sdrci_pkg::sdrci_op_e op, input logic [1:0] b,
                       input logic [10:0] a, input bit close = 1'b1);
    int need;
    @(posedge sys_clk);
    need = 0;
    if (op == sdrci_pkg::SDRCI_ACTIVATE) begin
      need = wr_done[b] + PRE_CLKS;
    end else if (op == sdrci_pkg::SDRCI_PRECHARGE) begin
      foreach (wr_done[i]) begin
        if ((a[`SDRCI_AUTO_PRE_BIT] || i == b) && wr_done[i] > need) begin
          need = wr_done[i];
        end
      end
    end
    while (clk_n < need) begin
      @(posedge sys_clk);
    end
    if (op == sdrci_pkg::SDRCI_MODE_LOAD) begin
      bl_code = a[`SDRCI_MODE_BL_LSB +: 3];
    end else if (op == sdrci_pkg::SDRCI_WRITE) begin
      wr_bank = b;
      wr_done[b] = (bl_code == `SDRCI_BL_FULL_PAGE) ? 32'h7FFFFFFF
                   : clk_n + beats(bl_code) + WR_CLKS - 1;
    end else if (op == sdrci_pkg::SDRCI_BURST_STOP) begin
      if (wr_done[wr_bank] > clk_n + WR_CLKS - 1) begin
        wr_done[wr_bank] = clk_n + WR_CLKS - 1;
      end
    end
    cmd <= {1'b0, op};
    ba <= b;
    addr <= a;
    if (close) begin
      @(posedge sys_clk);
      cmd <= 4'hF;
      ba <= ~b;
      addr <= ~a;
    end
  endtask
  // clock enable moves only at an edge, clock keeps running
  task automatic set_cke(input logic v);
    @(posedge sys_clk);
    cke <= v;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_sdrci_top.sv */
// self-checking bench for the sdram command sequencer
`default_nettype none
module tb_sdrci_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] code; logic [2:0] lat; int len;} sdrci_row_s;
  logic sys_clk;
  logic rstn;
  logic cke;
  sdrci_pkg::sdrci_cmd_s cmd;
  logic [1:0] ba;
  logic [10:0] addr;
  logic dq_oe;
  logic ready;
  logic [3:0] bank_open;
  logic [11:0] refresh_row;
  logic [7:0] col_addr;
  logic timing_err;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int first;
  int len;
  sdrci_row_s rows[5] = '{'{3'h0, 3'h3, 1}, '{3'h1, 3'h2, 2}, '{3'h2, 3'h1, 4},
                          '{3'h3, 3'h3, 8}, '{3'h4, 3'h2, 1}};
  sdrci_ctl_model u_ctl (.sys_clk(sys_clk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr));
  sdrci_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .cke(cke), .cmd(cmd), .ba(ba),
    .addr(addr), .dq_oe(dq_oe), .ready(ready), .bank_open(bank_open),
    .refresh_row(refresh_row), .col_addr(col_addr), .timing_err(timing_err));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic burst(output int f, output int n);
    f = 0;
    n = 0;
    for (int i = 1; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      if (dq_oe === 1'b1) begin
        if (f == 0) begin
          f = i;
        end
        n++;
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    rstn = 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk({dq_oe, ready, bank_open, refresh_row, col_addr, timing_err}, 32'h0);
    repeat (5000) @(posedge sys_clk);
    u_ctl.issue(sdrci_pkg::SDRCI_MODE_LOAD, 2'h0, 11'h032);
    u_ctl.issue(sdrci_pkg::SDRCI_READ, 2'h0, 11'h000);
    burst(first, len);
    chk(len, 0);
    u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h7FF);
    #1;
    chk(ready, 1'b0);
    u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h7FF);
    #1;
    chk({ready, refresh_row}, 13'h1002);
    u_ctl.issue(sdrci_pkg::SDRCI_ACTIVATE, 2'h1, 11'h000);
    #1;
    chk({timing_err, bank_open}, 5'h02);
    $display("test init done");
    foreach (rows[i]) begin
      u_ctl.issue(sdrci_pkg::SDRCI_MODE_LOAD, 2'h0, {4'h0, rows[i].lat, 1'b0, rows[i].code});
      u_ctl.issue(sdrci_pkg::SDRCI_READ, 2'h1, {3'h3, 8'(8'h10 + i)});
      #1;
      chk(col_addr, 8'(8'h10 + i));
      burst(first, len);
      chk(first, rows[i].lat);
      chk(len, rows[i].len);
    end
    $display("test burst rows done");
    u_ctl.issue(sdrci_pkg::SDRCI_MODE_LOAD, 2'h0, 11'h027);
    u_ctl.issue(sdrci_pkg::SDRCI_READ, 2'h1, 11'h000);
    burst(first, len);
    chk(len, 18);
    u_ctl.issue(sdrci_pkg::SDRCI_BURST_STOP, 2'h1, 11'h000);
    #1;
    chk({dq_oe, bank_open}, 5'h02);
    $display("test full page done");
    u_ctl.set_cke(1'b0);
    u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h000);
    u_ctl.set_cke(1'b1);
    #1;
    chk(refresh_row, 12'h002);
    u_ctl.issue(sdrci_pkg::SDRCI_PRECHARGE, 2'h1, 11'h000);
    #1;
    chk(bank_open, 4'h0);
    $display("test suspend and precharge done");
    u_ctl.issue(sdrci_pkg::SDRCI_MODE_LOAD, 2'h0, 11'h022);
    u_ctl.issue(sdrci_pkg::SDRCI_ACTIVATE, 2'h0, 11'h000);
    u_ctl.issue(sdrci_pkg::SDRCI_WRITE, 2'h0, 11'h305);
    #1;
    first = cyc;
    chk({col_addr, bank_open}, 12'h051);
    u_ctl.issue(sdrci_pkg::SDRCI_PRECHARGE, 2'h0, 11'h000);
    #1;
    chk(cyc - first, 3 + u_ctl.WR_CLKS);
    chk(bank_open, 4'h0);
    u_ctl.issue(sdrci_pkg::SDRCI_ACTIVATE, 2'h0, 11'h000);
    u_ctl.issue(sdrci_pkg::SDRCI_WRITE, 2'h0, 11'h405);
    #1;
    first = cyc;
    u_ctl.issue(sdrci_pkg::SDRCI_ACTIVATE, 2'h0, 11'h000);
    #1;
    chk(cyc - first, 3 + u_ctl.WR_CLKS + u_ctl.PRE_CLKS);
    chk(bank_open, 4'h1);
    $display("test write recovery done");
    u_ctl.issue(sdrci_pkg::SDRCI_MODE_LOAD, 2'h0, 11'h032, 1'b0);
    u_ctl.issue(sdrci_pkg::SDRCI_ACTIVATE, 2'h2, 11'h000);
    #1;
    chk(timing_err, 1'b1);
    $display("test short gap done");
    first = refresh_row;
    repeat (4095) u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h000);
    #1;
    chk(refresh_row, 12'(first - 1));
    u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h000);
    #1;
    chk(refresh_row, 12'(first));
    $display("test refresh wrap done");
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk({dq_oe, ready, bank_open, refresh_row, col_addr, timing_err}, 32'h0);
    repeat (2) @(posedge sys_clk);
    u_ctl.issue(sdrci_pkg::SDRCI_MODE_LOAD, 2'h0, 11'h032);
    u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h000);
    u_ctl.issue(sdrci_pkg::SDRCI_REFRESH, 2'h0, 11'h000);
    #1;
    chk({ready, refresh_row, timing_err}, 14'h2004);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
